/* src/gidr_cfg.svh */
// register offsets, field masks, reset values and timing counts of the pin control block
`ifndef GIDR_CFG_SVH
`define GIDR_CFG_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define GIDR_OFS_IRQ_EN_LO   8'h1f
`define GIDR_OFS_IRQ_EN_HI   8'h20
`define GIDR_OFS_DEB_BYP_LO  8'h21
`define GIDR_OFS_DEB_BYP_HI  8'h22
`define GIDR_OFS_OUT_LVL_LO  8'h23

// ---------------------------------------------------------------
// field masks and reset values
// ---------------------------------------------------------------
`define GIDR_MASK_LO_FULL    8'h3f
`define GIDR_MASK_LO_BASE    8'h1f
`define GIDR_MASK_HI         8'h1f
`define GIDR_RESET_VALUE     8'h00
`define GIDR_PIN_COUNT       11
`define GIDR_LO_PINS         6
`define GIDR_HI_PINS         5

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define GIDR_CLK_PERIOD_NS   20
`define GIDR_DEB_TIME_NS     1000
`define GIDR_DEB_CYCLES      ((`GIDR_DEB_TIME_NS + `GIDR_CLK_PERIOD_NS - 1) / `GIDR_CLK_PERIOD_NS)
`define GIDR_DEB_CNT_W       6

`endif

/* src/gidr_pkg.sv */
// types shared by the pin control block
package gidr_pkg;

  typedef logic [7:0] gidr_byte_t;

  // one-hot register select
  typedef enum logic [5:0] {
    GIDR_SEL_NONE   = 6'h01,
    GIDR_SEL_EN_LO  = 6'h02,
    GIDR_SEL_EN_HI  = 6'h04,
    GIDR_SEL_DEB_LO = 6'h08,
    GIDR_SEL_DEB_HI = 6'h10,
    GIDR_SEL_OUT_LO = 6'h20
  } gidr_sel_t;

endpackage : gidr_pkg

/* src/gidr_regs.sv */
// pin control registers: input interrupt enables, debounce bypass, output levels
`timescale 1ns/1ns
`include "gidr_cfg.svh"

module gidr_regs #(
  parameter bit SIXTH_PIN = 1'b0                          // extra-pin variant present
) (
  input  wire logic         clk_in,                       // 50 MHz core clock
  input  wire logic         rst_b_in,                     // async reset, active low
  input  wire logic [7:0]   reg_addr_in,                  // register offset
  input  wire logic [7:0]   reg_wdata_in,                 // write data
  input  wire logic         reg_wr_in,                    // write strobe, one cycle
  input  wire logic         reg_rd_in,                    // read strobe, one cycle
  input  wire logic [10:0]  general_input_in,             // input pin levels, async
  input  wire logic [10:0]  irq_polarity_in,              // level select per input
  input  wire logic [10:0]  fifo_logging_enable_in,       // event fifo mode per input
  input  wire logic [10:0]  irq_flag_clear_in,            // clear pulse per flag
  output logic [7:0]        reg_rdata_out,                // read data
  output logic [10:0]       input_irq_flag_out,           // per-input flags
  output logic [10:0]       input_level_out,              // debounced levels
  output logic              input_irq_summary_out,        // summary interrupt bit
  output logic [5:0]        general_output_out            // output levels 1-6
);

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  gidr_pkg::gidr_byte_t irq_en_lo;
  gidr_pkg::gidr_byte_t irq_en_hi;
  gidr_pkg::gidr_byte_t deb_byp_lo;
  gidr_pkg::gidr_byte_t deb_byp_hi;
  gidr_pkg::gidr_byte_t out_lvl_lo;
  gidr_pkg::gidr_sel_t  sel;
  gidr_pkg::gidr_byte_t lo_mask;

  logic [10:0] irq_en_all;
  logic [10:0] deb_byp_all;
  logic [10:0] sync1;
  logic [10:0] sync2;
  logic [10:0] sync3;
  logic [10:0] level;
  logic [10:0] cond;
  logic [10:0] next_flag;

  // sixth pin bit is reserved unless the variant has the pin
  // sixth pin gating
  assign lo_mask = SIXTH_PIN ? `GIDR_MASK_LO_FULL : `GIDR_MASK_LO_BASE;

  // address decode into a one-hot select
  always_comb begin
    unique case (reg_addr_in)
      `GIDR_OFS_IRQ_EN_LO:  sel = gidr_pkg::GIDR_SEL_EN_LO;
      `GIDR_OFS_IRQ_EN_HI:  sel = gidr_pkg::GIDR_SEL_EN_HI;
      `GIDR_OFS_DEB_BYP_LO: sel = gidr_pkg::GIDR_SEL_DEB_LO;
      `GIDR_OFS_DEB_BYP_HI: sel = gidr_pkg::GIDR_SEL_DEB_HI;
      `GIDR_OFS_OUT_LVL_LO: sel = gidr_pkg::GIDR_SEL_OUT_LO;
      default:              sel = gidr_pkg::GIDR_SEL_NONE;
    endcase
  end

  // writes; reserved bits are masked so they never store
  // masked writes
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_en_lo  <= `GIDR_RESET_VALUE;
      irq_en_hi  <= `GIDR_RESET_VALUE;
      deb_byp_lo <= `GIDR_RESET_VALUE;
      deb_byp_hi <= `GIDR_RESET_VALUE;
      out_lvl_lo <= `GIDR_RESET_VALUE;
    end else if (reg_wr_in) begin
      unique case (sel)
        gidr_pkg::GIDR_SEL_EN_LO:  irq_en_lo  <= reg_wdata_in & lo_mask;
        gidr_pkg::GIDR_SEL_EN_HI:  irq_en_hi  <= reg_wdata_in & `GIDR_MASK_HI;
        gidr_pkg::GIDR_SEL_DEB_LO: deb_byp_lo <= reg_wdata_in & lo_mask;
        gidr_pkg::GIDR_SEL_DEB_HI: deb_byp_hi <= reg_wdata_in & `GIDR_MASK_HI;
        gidr_pkg::GIDR_SEL_OUT_LO: out_lvl_lo <= reg_wdata_in & lo_mask;
        gidr_pkg::GIDR_SEL_NONE:   ;
      endcase
    end
  end

  // read path; unmapped offsets answer zero
  // zero for unmapped
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= `GIDR_RESET_VALUE;
    end else if (reg_rd_in) begin
      unique case (sel)
        gidr_pkg::GIDR_SEL_EN_LO:  reg_rdata_out <= irq_en_lo;
        gidr_pkg::GIDR_SEL_EN_HI:  reg_rdata_out <= irq_en_hi;
        gidr_pkg::GIDR_SEL_DEB_LO: reg_rdata_out <= deb_byp_lo;
        gidr_pkg::GIDR_SEL_DEB_HI: reg_rdata_out <= deb_byp_hi;
        gidr_pkg::GIDR_SEL_OUT_LO: reg_rdata_out <= out_lvl_lo;
        gidr_pkg::GIDR_SEL_NONE:   reg_rdata_out <= `GIDR_RESET_VALUE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // outputs 1-6
  // ---------------------------------------------------------------
  // output levels follow register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      general_output_out <= 6'h00;
    end else begin
      general_output_out <= out_lvl_lo[5:0];
    end
  end

  // ---------------------------------------------------------------
  // input synchroniser and debounce
  // ---------------------------------------------------------------
  assign irq_en_all  = {irq_en_hi[4:0], irq_en_lo[5:0]};
  assign deb_byp_all = {deb_byp_hi[4:0], deb_byp_lo[5:0]};

  // three stages; sync1 feeds only sync2 to keep metastability contained
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1 <= 11'h000;
      sync2 <= 11'h000;
      sync3 <= 11'h000;
    end else begin
      sync1 <= general_input_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `GIDR_PIN_COUNT; gi++) begin : g_pin
      logic [`GIDR_DEB_CNT_W-1:0] cnt;
      logic                       agree;
      logic                       lvl;
      assign agree     = (sync2[gi] == sync3[gi]);
      // each pin owns its accepted level; the vector only gathers them
      assign level[gi] = lvl;

      // a new level counts only after the debounce window of agreement;
      // a glitch restarts the window, trading latency for noise immunity
      // debounce or bypass
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          cnt <= '0;
          lvl <= 1'b0;
        end else if (!agree || (sync3[gi] == lvl)) begin
          cnt <= '0;
        end else if (deb_byp_all[gi] ||
                     (cnt == `GIDR_DEB_CNT_W'(`GIDR_DEB_CYCLES - 1))) begin
          cnt <= '0;
          lvl <= sync3[gi];
        end else begin
          cnt <= cnt + `GIDR_DEB_CNT_W'(1);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      input_level_out <= 11'h000;
    end else begin
      input_level_out <= level;
    end
  end

  // ---------------------------------------------------------------
  // interrupt flags and summary
  // ---------------------------------------------------------------
  // polarity selects condition
  assign cond = ~(level ^ irq_polarity_in);

  // set wins over a clear in the same cycle so no event is lost
  // fifo mode blocks flag
  assign next_flag = (input_irq_flag_out & ~irq_flag_clear_in) |
                     (cond & ~fifo_logging_enable_in);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      input_irq_flag_out <= 11'h000;
    end else begin
      input_irq_flag_out <= next_flag;
    end
  end

  // summary is a level: it drops as soon as no enabled cause remains
  // gated summary
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      input_irq_summary_out <= 1'b0;
    end else begin
      input_irq_summary_out <= |(input_irq_flag_out & irq_en_all & cond &
                                 ~fifo_logging_enable_in);
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // summary needs enabled flag
  a_summary_cause : assert property (@(posedge clk_in) disable iff (!rst_b_in)
    input_irq_summary_out |-> $past(|(input_irq_flag_out & irq_en_all)))
    else $error("summary set without an enabled flag");

  a_disabled_quiet : assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (irq_en_all == 11'h000) [*2] |-> !input_irq_summary_out)
    else $error("summary set with all enables off");

  a_summary_live : assert property (@(posedge clk_in) disable iff (!rst_b_in)
    input_irq_summary_out |-> $past(|(irq_en_all & cond & ~fifo_logging_enable_in)))
    else $error("summary set without a live enabled cause");

  a_enlo_reserved : assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (irq_en_lo & ~lo_mask) == 8'h00)
    else $error("reserved enable low bits stored");

  a_enhi_reserved : assert property (@(posedge clk_in) disable iff (!rst_b_in)
    irq_en_hi[7:5] == 3'h0)
    else $error("reserved enable high bits stored");

  a_sixth_gate : assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !SIXTH_PIN |-> !(irq_en_lo[5] | deb_byp_lo[5] | out_lvl_lo[5]))
    else $error("sixth pin bit stored on base variant");

  a_deb_reserved : assert property (@(posedge clk_in) disable iff (!rst_b_in)
    deb_byp_lo[7:6] == 2'h0 && deb_byp_hi[7:5] == 3'h0)
    else $error("reserved debounce bits stored");

  a_output_write : assert property (@(posedge clk_in) disable iff (!rst_b_in)
    reg_wr_in && reg_addr_in == `GIDR_OFS_OUT_LVL_LO
      |-> ##2 general_output_out == $past(reg_wdata_in[5:0] & lo_mask[5:0], 2))
    else $error("output level not written");

  a_out_reserved : assert property (@(posedge clk_in) disable iff (!rst_b_in)
    out_lvl_lo[7:6] == 2'h0)
    else $error("reserved output bits stored");

  a_bypass_fast : assert property (@(posedge clk_in) disable iff (!rst_b_in)
    deb_byp_all[0] && sync2[0] == sync3[0] && sync3[0] != level[0]
      |=> level[0] == $past(sync3[0]))
    else $error("bypassed input not taken at once");

  a_debounce_wait : assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $changed(level[0]) && !$past(deb_byp_all[0])
      |-> $past(g_pin[0].cnt) == `GIDR_DEB_CNT_W'(`GIDR_DEB_CYCLES - 1))
    else $error("debounced level changed early");

  a_flag_cause : assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(input_irq_flag_out[0])
      |-> $past(!fifo_logging_enable_in[0] &&
                level[0] == irq_polarity_in[0]))
    else $error("flag set without its level condition");

  a_fifo_blocks : assert property (@(posedge clk_in) disable iff (!rst_b_in)
    fifo_logging_enable_in[0] |=> !$rose(input_irq_flag_out[0]))
    else $error("flag rose while its input logs to the fifo");

  a_set_wins : assert property (@(posedge clk_in) disable iff (!rst_b_in)
    irq_flag_clear_in[0] && cond[0] && !fifo_logging_enable_in[0]
      |=> input_irq_flag_out[0])
    else $error("flag clear beat a simultaneous set");

  a_unmapped_zero : assert property (@(posedge clk_in) disable iff (!rst_b_in)
    reg_rd_in && sel == gidr_pkg::GIDR_SEL_NONE |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");

  c_summary : cover property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(input_irq_summary_out));
  c_debounced : cover property (@(posedge clk_in) disable iff (!rst_b_in)
    $changed(level[0]) && !deb_byp_all[0]);
  c_set_clear : cover property (@(posedge clk_in) disable iff (!rst_b_in)
    irq_flag_clear_in[0] && cond[0] && !fifo_logging_enable_in[0]);
  c_fifo_blocked : cover property (@(posedge clk_in) disable iff (!rst_b_in)
    fifo_logging_enable_in[1] && cond[1]);

endmodule : gidr_regs

/* verification/gidr_host.sv */
// host model that issues strobe accesses to the pin control registers
`timescale 1ns/1ns

module gidr_host (
  input  wire logic       clk_in,    // core clock
  output logic      [7:0] addr_out,  // register offset
  output logic      [7:0] wdata_out, // write data
  output logic            wr_out,    // write strobe
  output logic            rd_out     // read strobe
);
  initial begin
    addr_out  = 8'h00;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  // one-cycle write; the idle bus shows inverted values so stale data never looks live
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask : wr

  // one-cycle read, data follows one edge later
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
  endtask : rd
endmodule : gidr_host

/* verification/tb.sv */
// self-checking bench for the pin control registers
`timescale 1ns/1ns
`include "gidr_cfg.svh"

module tb;
  logic        clk_in, rst_b_in, wr, rd, summary;
  logic        pend = 1'b0;
  logic [7:0]  addr, wdata, rdata, d;
  logic [10:0] pins, pol, fifo, clr, flag, level;
  logic [5:0]  gout;
  logic [7:0]  exp_q[$];
  logic [7:0]  ofs[5];
  logic [7:0]  msk[5];
  int          err_count, cmp_count, i, j;
  integer      seed;

  gidr_host gidr_host_i (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd));
  gidr_regs gidr_regs_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .general_input_in(pins),
    .irq_polarity_in(pol), .fifo_logging_enable_in(fifo), .irq_flag_clear_in(clr),
    .reg_rdata_out(rdata), .input_irq_flag_out(flag), .input_level_out(level),
    .input_irq_summary_out(summary), .general_output_out(gout));

  // ---------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // read data is compared one edge after the strobe is taken
  always @(posedge clk_in) begin
    if (pend) begin
      chk("reg_rdata_out", {3'h0, exp_q.pop_front()}, {3'h0, rdata});
    end
    pend <= rd;
  end

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    gidr_host_i.rd(a);
  endtask : rd_chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------
  // clock, watchdog, stimulus
  // ---------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // whole run is under 1500 cycles, so this only trips on a hang
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    complete_run();
  end

  initial begin
    seed = 32'he4a7;
    rst_b_in = 1'b0;
    pins = 11'h7ff;
    pol = 11'h000;
    fifo = 11'h000;
    clr = 11'h000;
    ofs = '{`GIDR_OFS_IRQ_EN_LO, `GIDR_OFS_IRQ_EN_HI, `GIDR_OFS_DEB_BYP_LO,
            `GIDR_OFS_DEB_BYP_HI, `GIDR_OFS_OUT_LVL_LO};
    msk = '{`GIDR_MASK_LO_BASE, `GIDR_MASK_HI, `GIDR_MASK_LO_BASE, `GIDR_MASK_HI,
            `GIDR_MASK_LO_BASE};
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (i = 0; i < 5; i++) begin
      rd_chk(ofs[i], `GIDR_RESET_VALUE);
    end
    rd_chk(8'h24, 8'h00);
    $display("test reset_values done");
    // all-ones first so reserved and sixth-pin bits are exercised
    for (j = 0; j < 3; j++) begin
      for (i = 0; i < 5; i++) begin
        d = (j == 0) ? 8'hff : 8'($random(seed));
        gidr_host_i.wr(ofs[i], d);
        rd_chk(ofs[i], d & msk[i]);
      end
    end
    gidr_host_i.wr(8'h24, 8'hff);
    rd_chk(8'h24, 8'h00);
    $display("test register_access done");
    for (j = 0; j < 4; j++) begin
      d = (j == 0) ? 8'h3f : 8'($random(seed));
      gidr_host_i.wr(`GIDR_OFS_OUT_LVL_LO, d);
      repeat (3) @(posedge clk_in);
      #1;
      chk("general_output_out", {5'h00, d[5:0] & 6'h1f}, {5'h00, gout});
    end
    $display("test output_levels done");
    gidr_host_i.wr(`GIDR_OFS_DEB_BYP_LO, 8'h1f);
    gidr_host_i.wr(`GIDR_OFS_DEB_BYP_HI, 8'h1f);
    gidr_host_i.wr(`GIDR_OFS_IRQ_EN_HI, 8'h00);
    gidr_host_i.wr(`GIDR_OFS_IRQ_EN_LO, 8'h03);
    // flags went sticky while levels sat low after reset; clear them first
    @(posedge clk_in);
    clr <= 11'h7ff;
    @(posedge clk_in);
    clr <= 11'h000;
    fifo <= 11'h002;
    pins <= 11'h7fc;
    repeat (10) @(posedge clk_in);
    #1;
    chk("input_irq_summary_out", 11'h001, {10'h000, summary});
    chk("input_irq_flag_out", 11'h001, flag & 11'h003);
    // a clear that meets a live condition must lose
    @(posedge clk_in);
    clr <= 11'h001;
    @(posedge clk_in);
    clr <= 11'h000;
    @(posedge clk_in);
    #1;
    chk("input_irq_flag_out", 11'h001, flag & 11'h001);
    gidr_host_i.wr(`GIDR_OFS_IRQ_EN_LO, 8'h00);
    repeat (4) @(posedge clk_in);
    #1;
    chk("input_irq_summary_out", 11'h000, {10'h000, summary});
    gidr_host_i.wr(`GIDR_OFS_IRQ_EN_HI, 8'h01);
    pol <= 11'h040;
    repeat (10) @(posedge clk_in);
    #1;
    chk("input_irq_summary_out", 11'h001, {10'h000, summary});
    $display("test interrupts done");
    // input 8 debounced: a short glitch must not pass, a long level must
    gidr_host_i.wr(`GIDR_OFS_DEB_BYP_HI, 8'h1d);
    pins[7] <= 1'b0;
    repeat (20) @(posedge clk_in);
    pins[7] <= 1'b1;
    #1;
    chk("input_level_out", 11'h001, {10'h000, level[7]});
    repeat (60) @(posedge clk_in);
    #1;
    chk("input_level_out", 11'h001, {10'h000, level[7]});
    pins[7] <= 1'b0;
    repeat (40) @(posedge clk_in);
    #1;
    chk("input_level_out", 11'h001, {10'h000, level[7]});
    repeat (30) @(posedge clk_in);
    #1;
    chk("input_level_out", 11'h000, {10'h000, level[7]});
    $display("test debounce done");
    repeat (3) @(posedge clk_in);
    complete_run();
  end
endmodule : tb
